// File: dv/gpmd_checker.sv
// Purpose: Assertions on the register port and pad controls of gpmd_top.
// Assumes: One mclk domain, synchronous active-low reset.
// Notes:   Sees top ports only, so pin modes are inferred from pad controls.
`timescale 1ns/1ps
module gpmd_checker #(
    parameter int NPORT = 4,
    parameter int NPIN  = 16
) (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input gpmd_pkg::gpmd_bus_req_t          busReq,
    input gpmd_pkg::gpmd_bus_rsp_t          busRsp,
    input wire logic [NPORT-1:0][NPIN-1:0]  padIn,
    input wire logic [NPORT-1:0][NPIN-1:0]  padOutEn,
    input wire logic [NPORT-1:0][NPIN-1:0]  pullAllow,
    input wire logic [NPORT-1:0][NPIN-1:0]  triggerEn,
    input wire logic [NPORT-1:0][NPIN-1:0]  altSelected,
    input wire logic [NPORT-1:0][NPIN-1:0]  inputSample
);
    import gpmd_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic mapped;
    logic rd;
    // Blocks A, B, C and F only; the gap between C and F must not decode
    assign mapped = busReq.addr[31:13] == 19'h2_4000
                    && busReq.addr[12:10] inside {3'h0, 3'h1, 3'h2, 3'h5};
    assign rd = busReq.sel && !busReq.write && mapped;

    chk_ready_latency: assert property ($past(rst_n) |-> busRsp.ready == $past(busReq.sel))
        else $error("ready does not follow the request by one cycle");
    chk_err_unmapped: assert property (busReq.sel && !mapped |=> busRsp.err && busRsp.rdata == 32'h0)
        else $error("unmapped access not flagged");
    chk_err_mapped: assert property (busReq.sel && mapped |=> !busRsp.err)
        else $error("mapped access flagged as error");
    chk_rsvd_offset: assert property (rd && !(busReq.addr[9:0] inside {10'h000, 10'h004}) |=> busRsp.rdata == 32'h0)
        else $error("reserved offset read not zero");
    chk_drive_upper: assert property (rd && busReq.addr[9:0] == 10'h004 |=> busRsp.rdata[31:16] == 16'h0)
        else $error("drive type upper half not zero");
    chk_analog_quiet: assert property (pullAllow == triggerEn && (~pullAllow & (inputSample | padOutEn)) == '0)
        else $error("analog pin not quiet");
    chk_sample_pad: assert property ($past(rst_n) |-> ((inputSample ^ $past(padIn)) & triggerEn) == '0)
        else $error("input sample does not follow pad");
    chk_reset_altfn: assert property ($rose(rst_n) |=> altSelected == 64'h0000_0000_0000_6000)
        else $error("reset alternate function pins wrong");

    cover property (busReq.sel && busReq.write && mapped);
    cover property (busRsp.err);
    cover property (pullAllow != '1);
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench for the pin mode and drive type registers.
// Assumes: One-cycle response, pads registered one edge after config.
// Notes:   Pad behaviour is exercised on port C, bar one port A altSelected reset check, to save run time.
`timescale 1ns/1ps
module tb;
    import gpmd_pkg::*;
    logic             mclk;
    logic             rst_n;
    gpmd_bus_req_t    busReq;
    gpmd_bus_rsp_t    busRsp;
    logic [3:0][15:0] outputLatch, altOut, altOutEn, padIn, padOut, padOutEn;
    logic [3:0][15:0] pullAllow, triggerEn, altSelected, inputSample;
    int               failures;
    int               n_checks;
    localparam logic [31:0] BASE [4] = '{32'h4800_0000, 32'h4800_0400,
                                         32'h4800_0800, 32'h4800_1400};

    gpmd_top uut (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .busRsp(busRsp),
        .outputLatch(outputLatch), .altOut(altOut), .altOutEn(altOutEn), .padIn(padIn),
        .padOut(padOut), .padOutEn(padOutEn), .pullAllow(pullAllow), .triggerEn(triggerEn),
        .altSelected(altSelected), .inputSample(inputSample));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One request, released at the edge that takes it, answer checked next cycle
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] exp, input logic e);
        @(posedge mclk);
        busReq <= '{1'b1, wr, a, d, s};
        @(posedge mclk);
        busReq.sel <= 1'b0;
        #1;
        check({30'h0, busRsp.ready, busRsp.err, busRsp.rdata}, {30'h0, 1'b1, e, exp});
    endtask

    task automatic pads(input logic [15:0] o, input logic [15:0] en, input logic [15:0] pa,
                        input logic [15:0] al, input logic [15:0] smp);
        @(posedge mclk);
        #1;
        check({padOut[2], padOutEn[2], pullAllow[2], altSelected[2]}, {o, en, pa, al});
        check({32'h0, inputSample[2], triggerEn[2]}, {32'h0, smp, pa});
    endtask

    task automatic close_out;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        close_out;
    end

    initial begin
        rst_n = 1'b0;
        busReq = '0;
        outputLatch = '0;
        altOut = '0;
        altOutEn = '0;
        padIn = '0;
        failures = 0;
        n_checks = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int p = 0; p < 4; p++) begin
            acc(1'b0, BASE[p], 32'h0, 4'hF, (p == 0) ? 32'h2800_0000 : 32'h0, 1'b0);
            acc(1'b0, BASE[p] + 32'h4, 32'h0, 4'hF, 32'h0, 1'b0);
            acc(1'b1, BASE[p], 32'h1B1B_0000 | p, 4'hF, 32'h0, 1'b0);
            acc(1'b1, BASE[p] + 32'h4, 32'h0000_A5A0 | p, 4'hF, 32'h0, 1'b0);
        end
        // Read back only after all four are written, so cross-block aliasing shows
        for (int p = 0; p < 4; p++) begin
            acc(1'b0, BASE[p], 32'h0, 4'hF, 32'h1B1B_0000 | p, 1'b0);
            acc(1'b0, BASE[p] + 32'h4, 32'h0, 4'hF, 32'h0000_A5A0 | p, 1'b0);
        end
        acc(1'b1, BASE[1], 32'h5555_5555, 4'h2, 32'h0, 1'b0);
        acc(1'b0, BASE[1], 32'h0, 4'hF, 32'h1B1B_5501, 1'b0);
        acc(1'b1, BASE[3] + 32'h8, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
        acc(1'b0, BASE[3] + 32'h8, 32'h0, 4'hF, 32'h0, 1'b0);
        // Offset 0x100 shares its low byte with the mode word and must not alias
        acc(1'b1, BASE[3] + 32'h100, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b0);
        acc(1'b0, BASE[3] + 32'h104, 32'h0, 4'hF, 32'h0, 1'b0);
        acc(1'b0, BASE[3], 32'h0, 4'hF, 32'h1B1B_0003, 1'b0);
        acc(1'b1, 32'h4800_0C00, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
        acc(1'b0, 32'h4800_0C00, 32'h0, 4'hF, 32'h0, 1'b1);
        @(posedge mclk);
        outputLatch[2] <= 16'h0002;
        altOut[2] <= 16'h0004;
        altOutEn[2] <= 16'h0004;
        padIn[2] <= 16'h000F;
        acc(1'b1, BASE[2] + 32'h4, 32'h0, 4'hF, 32'h0, 1'b0);
        // Pins 0..3 take input, output, alternate and analog in turn
        acc(1'b1, BASE[2], 32'h0000_00E4, 4'hF, 32'h0, 1'b0);
        pads(16'h0006, 16'h0006, 16'hFFF7, 16'h0004, 16'h0007);
        acc(1'b1, BASE[2] + 32'h4, 32'h0000_0006, 4'hF, 32'h0, 1'b0);
        pads(16'h0000, 16'h0000, 16'hFFF7, 16'h0004, 16'h0007);
        @(posedge mclk);
        outputLatch[2] <= 16'h0000;
        altOut[2] <= 16'h0000;
        padIn[2] <= 16'h0009;
        pads(16'h0000, 16'h0006, 16'hFFF7, 16'h0004, 16'h0001);
        // A reset in mid-run must bring back the reset words over written ones
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        acc(1'b0, BASE[0], 32'h0, 4'hF, 32'h2800_0000, 1'b0);
        acc(1'b0, BASE[2], 32'h0, 4'hF, 32'h0, 1'b0);
        acc(1'b0, BASE[2] + 32'h4, 32'h0, 4'hF, 32'h0, 1'b0);
        pads(16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0009);
        check({48'h0, altSelected[0]}, {48'h0, 16'h6000});
        close_out;
    end
endmodule

bind gpmd_top gpmd_checker #(.NPORT(NPORT), .NPIN(NPIN)) chk (.mclk(mclk), .rst_n(rst_n),
    .busReq(busReq), .busRsp(busRsp), .padIn(padIn), .padOutEn(padOutEn),
    .pullAllow(pullAllow), .triggerEn(triggerEn), .altSelected(altSelected),
    .inputSample(inputSample));

// File: verilog/gpmd_defines.svh
// Purpose: Constants for the pin mode and drive type register block.
// Assumes: Four port blocks of sixteen pins on a 32-bit register port.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - Ports A, B, C, F decode at separate fixed bases, port A lowest.
// - Mode control at offset 0, two bits per pin, pin n at 2n+1:2n.
// - Mode 00 input (default), 01 output, 10 alternate function, 11 analog.
// - Port A mode resets to 0x28000000, other ports reset to zero.
// - Drive type at offset 4, one bit per pin, pin n at bit n.
// - Drive bit 0 gives push-pull, 1 gives open-drain.
// - Drive type resets to zero on every port.
// - Open-drain pulls low for latch 0, floats for 1; push-pull drives both.
// - Analog disables output, pulls and trigger; input sample reads 0.
// - Other modes sample every pad level into input sample each cycle.
`ifndef GPMD_DEFINES_SVH
`define GPMD_DEFINES_SVH

`define GPMD_BASE_A        32'h4800_0000
`define GPMD_BASE_B        32'h4800_0400
`define GPMD_BASE_C        32'h4800_0800
`define GPMD_BASE_F        32'h4800_1400
`define GPMD_BLOCK_LSB     10
`define GPMD_OFS_MODE      8'h00
`define GPMD_OFS_DRIVE     8'h04
`define GPMD_MODE_RST_A    32'h2800_0000
`define GPMD_MODE_RST_OTH  32'h0000_0000
`define GPMD_DRIVE_RST     16'h0000
`define GPMD_MODE_INPUT    2'h0
`define GPMD_MODE_OUTPUT   2'h1
`define GPMD_MODE_ALTFN    2'h2
`define GPMD_MODE_ANALOG   2'h3
`define GPMD_DRIVE_PP      1'h0
`define GPMD_DRIVE_OD      1'h1

`endif

// File: verilog/gpmd_pkg.sv
// Purpose: Shared types for the pin mode and drive type register block.
// Assumes: Register port carries full 32-bit words with byte strobes.
// Notes:   Constants live in gpmd_defines.svh.
package gpmd_pkg;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  strb;
    } gpmd_bus_req_t;

    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } gpmd_bus_rsp_t;

    typedef struct packed {
        logic [31:0] mode;
        logic [15:0] drive;
    } gpmd_cfg_t;

endpackage

// File: verilog/gpmd_port.sv
// Purpose: Configuration registers of one port block.
// Assumes: Caller decodes the block; offset is the low byte of the address.
// Notes:   Reset value of the mode word is set per instance.
`timescale 1ns/1ps
`include "gpmd_defines.svh"
module gpmd_port #(
    parameter logic [31:0] MODE_RESET = `GPMD_MODE_RST_OTH
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             wrEn,
    input  wire logic [7:0]       offset,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       strb,
    output gpmd_pkg::gpmd_cfg_t   cfg
);
    import gpmd_pkg::*;

    logic [31:0] mode_reg;
    logic [15:0] drive_reg;
    logic [31:0] strbMask;

    always_comb begin
        strbMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end

    // Only the strobed bytes change, so a byte write leaves other pins alone
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_reg <= MODE_RESET;
        end else if (wrEn && offset == `GPMD_OFS_MODE) begin
            mode_reg <= (mode_reg & ~strbMask) | (wdata & strbMask);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            drive_reg <= `GPMD_DRIVE_RST;
        end else if (wrEn && offset == `GPMD_OFS_DRIVE) begin
            // Upper half is not stored at all
            drive_reg <= (drive_reg & ~strbMask[15:0]) | (wdata[15:0] & strbMask[15:0]);
        end
    end

    assign cfg = '{mode: mode_reg, drive: drive_reg};

endmodule

// File: verilog/gpmd_top.sv
// Purpose: Pin mode and drive type registers for four ports, with pad control.
// Assumes: Pads, latch and peripheral signals are synchronous to mclk.
// Notes:   Pad controls and read data are registered, one cycle behind config.
`timescale 1ns/1ps
`include "gpmd_defines.svh"
module gpmd_top #(
    parameter int NPORT = 4,
    parameter int NPIN  = 16
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  gpmd_pkg::gpmd_bus_req_t          busReq,
    output gpmd_pkg::gpmd_bus_rsp_t          busRsp,
    input  wire logic [NPORT-1:0][NPIN-1:0]  outputLatch,
    input  wire logic [NPORT-1:0][NPIN-1:0]  altOut,
    input  wire logic [NPORT-1:0][NPIN-1:0]  altOutEn,
    input  wire logic [NPORT-1:0][NPIN-1:0]  padIn,
    output logic      [NPORT-1:0][NPIN-1:0]  padOut,
    output logic      [NPORT-1:0][NPIN-1:0]  padOutEn,
    output logic      [NPORT-1:0][NPIN-1:0]  pullAllow,
    output logic      [NPORT-1:0][NPIN-1:0]  triggerEn,
    output logic      [NPORT-1:0][NPIN-1:0]  altSelected,
    output logic      [NPORT-1:0][NPIN-1:0]  inputSample
);
    import gpmd_pkg::*;

    // Four bases only: a larger NPORT needs more entries in these tables
    localparam logic [31:0] BASES [4] = '{`GPMD_BASE_A, `GPMD_BASE_B,
                                          `GPMD_BASE_C, `GPMD_BASE_F};
    localparam logic [31:0] MODE_RESETS [4] = '{`GPMD_MODE_RST_A, `GPMD_MODE_RST_OTH,
                                               `GPMD_MODE_RST_OTH, `GPMD_MODE_RST_OTH};

    gpmd_cfg_t           cfg [NPORT];
    logic [NPORT-1:0]    blockHit;
    logic [NPORT-1:0]    portWrite;
    logic                offsetMapped;
    logic [31:0]         readWord;
    logic [31:0]         rdata_reg;
    logic                ready_reg;
    logic                err_reg;

    logic [NPORT-1:0][NPIN-1:0] padOut_reg;
    logic [NPORT-1:0][NPIN-1:0] padOutEn_reg;
    logic [NPORT-1:0][NPIN-1:0] pullAllow_reg;
    logic [NPORT-1:0][NPIN-1:0] triggerEn_reg;
    logic [NPORT-1:0][NPIN-1:0] altSelected_reg;
    logic [NPORT-1:0][NPIN-1:0] inputSample_reg;
    logic [NPORT-1:0][NPIN-1:0] padOut_next;
    logic [NPORT-1:0][NPIN-1:0] padOutEn_next;
    logic [NPORT-1:0][NPIN-1:0] pullAllow_next;
    logic [NPORT-1:0][NPIN-1:0] triggerEn_next;
    logic [NPORT-1:0][NPIN-1:0] altSelected_next;
    logic [NPORT-1:0][NPIN-1:0] inputSample_next;

    // Each block compares only the bits above its 1 KiB window
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            blockHit[p] = busReq.sel &&
                (busReq.addr[31:`GPMD_BLOCK_LSB] == BASES[p][31:`GPMD_BLOCK_LSB]);
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            gpmd_port #(
                .MODE_RESET (MODE_RESETS[gp])
            ) u_port (
                .mclk   (mclk),
                .rst_n  (rst_n),
                .wrEn   (portWrite[gp]),
                .offset (busReq.addr[7:0]),
                .wdata  (busReq.wdata),
                .strb   (busReq.strb),
                .cfg    (cfg[gp])
            );
        end
    endgenerate

    // Full ten-bit offset must match, not just the low byte
    always_comb begin
        offsetMapped = (busReq.addr[`GPMD_BLOCK_LSB-1:8] == '0) &&
                       ((busReq.addr[7:0] == `GPMD_OFS_MODE) ||
                        (busReq.addr[7:0] == `GPMD_OFS_DRIVE));
    end

    // Without the offset check a write at 0x100 would alias onto offset 0
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            portWrite[p] = blockHit[p] && busReq.write && offsetMapped;
        end
    end

    // Other offsets inside a block read zero; writes there are dropped
    always_comb begin
        readWord = 32'h0000_0000;
        for (int p = 0; p < NPORT; p++) begin
            if (blockHit[p] && busReq.addr[`GPMD_BLOCK_LSB-1:8] == '0) begin
                if (busReq.addr[7:0] == `GPMD_OFS_MODE) begin
                    readWord = cfg[p].mode;
                end else if (busReq.addr[7:0] == `GPMD_OFS_DRIVE) begin
                    readWord = {16'h0000, cfg[p].drive};
                end
            end
        end
    end

    // Answer one cycle after the request; error only outside every block
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            ready_reg <= busReq.sel;
            err_reg   <= busReq.sel && (blockHit == '0);
        end
    end

    // Read data is zero outside a read answer, so a stale word never shows
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= (busReq.sel && !busReq.write && offsetMapped) ? readWord : 32'h0000_0000;
        end
    end

    // Per-pin pad control from mode and drive type
    always_comb begin
        logic [1:0] m;
        logic       od;
        logic       drv;
        logic       val;
        m   = `GPMD_MODE_INPUT;
        od  = `GPMD_DRIVE_PP;
        drv = 1'b0;
        val = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            for (int n = 0; n < NPIN; n++) begin
                m   = cfg[p].mode[2*n +: 2];
                od  = cfg[p].drive[n];
                drv = 1'b0;
                val = 1'b0;
                case (m)
                    `GPMD_MODE_OUTPUT: begin
                        drv = 1'b1;
                        val = outputLatch[p][n];
                    end
                    `GPMD_MODE_ALTFN: begin
                        // The peripheral decides direction in this mode
                        drv = altOutEn[p][n];
                        val = altOut[p][n];
                    end
                    default: begin
                        // Input and analog pins never drive the pad
                        drv = 1'b0;
                        val = 1'b0;
                    end
                endcase
                if (od == `GPMD_DRIVE_OD) begin
                    // Never drives high; a high level is left to the pad's pull-up
                    padOut_next[p][n]   = 1'b0;
                    padOutEn_next[p][n] = drv && !val;
                end else begin
                    padOut_next[p][n]   = val;
                    padOutEn_next[p][n] = drv;
                end
                pullAllow_next[p][n]   = (m != `GPMD_MODE_ANALOG);
                triggerEn_next[p][n]   = (m != `GPMD_MODE_ANALOG);
                altSelected_next[p][n] = (m == `GPMD_MODE_ALTFN);
                // Analog pins read zero; the mode gates the sample as it gates the trigger
                inputSample_next[p][n] = (m != `GPMD_MODE_ANALOG) && padIn[p][n];
            end
        end
    end

    // Pads follow a config write one edge late, at the same edge as the earliest read answer with the new word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            padOut_reg   <= '0;
            padOutEn_reg <= '0;
        end else begin
            padOut_reg   <= padOut_next;
            padOutEn_reg <= padOutEn_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            altSelected_reg <= '0;
        end else begin
            altSelected_reg <= altSelected_next;
        end
    end

    // Reset leaves pins as inputs, bar port A pins 13 and 14 in alternate function, with pulls and trigger allowed
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pullAllow_reg <= '1;
            triggerEn_reg <= '1;
        end else begin
            pullAllow_reg <= pullAllow_next;
            triggerEn_reg <= triggerEn_next;
        end
    end

    // Sampled every cycle with no filter; the pad is taken as already synchronous
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            inputSample_reg <= '0;
        end else begin
            inputSample_reg <= inputSample_next;
        end
    end

    assign busRsp      = '{ready: ready_reg, err: err_reg, rdata: rdata_reg};
    assign padOut      = padOut_reg;
    assign padOutEn    = padOutEn_reg;
    assign pullAllow   = pullAllow_reg;
    assign triggerEn   = triggerEn_reg;
    assign altSelected = altSelected_reg;
    assign inputSample = inputSample_reg;

endmodule
